/* File: sim/rbt_bus_partner.sv */
// Far-side model: other drivers on the A and B buses, and the wire levels.
// Assumes the bench sets driver values and enables just after a clock edge.
`timescale 1ns/10ps
module rbt_bus_partner (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_a_drv,
    input  wire logic       i_a_drv_en,
    input  wire logic [7:0] i_b_drv,
    input  wire logic       i_b_drv_en,
    input  wire logic [7:0] i_a_dev,
    input  wire logic       i_a_dev_oe_n,
    input  wire logic [7:0] i_b_dev,
    input  wire logic       i_b_dev_oe_n,
    output logic      [7:0] o_a_wire,
    output logic      [7:0] o_b_wire
);
    logic [7:0] a_last_q;
    logic [7:0] b_last_q;
    // A wire nobody drives flips every cycle instead of keeping a stale level
    always_comb
    begin
        o_a_wire = !i_a_dev_oe_n ? i_a_dev : (i_a_drv_en ? i_a_drv : ~a_last_q);
        o_b_wire = !i_b_dev_oe_n ? i_b_dev : (i_b_drv_en ? i_b_drv : ~b_last_q);
    end
    always_ff @(posedge i_clk)
    begin
        a_last_q <= o_a_wire;
        b_last_q <= o_b_wire;
    end
endmodule // rbt_bus_partner

/* File: sim/testbench.sv */
// Self-checking bench for the registered bus transceiver.
// Assumes the design's 3-cycle pin-to-pin latency; 8 cycles are allowed.
`timescale 1ns/10ps
module testbench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       a_cap = 1'b0, b_cap = 1'b0, a_sel = 1'b0, b_sel = 1'b0;
    logic       b_en = 1'b0, a_en_n = 1'b1, a_drv_en = 1'b1, b_drv_en = 1'b1;
    logic [7:0] a_drv = 8'h00, b_drv = 8'h00, a_wire, b_wire, a_out, b_out;
    logic       a_oe_n, b_oe_n;
    int         miscompares = 0;
    int         samples_checked = 0;
    always #5 clk = ~clk;
    rbt_transceiver #(.WIDTH(8)) rbt_transceiver_inst (.i_clk(clk), .i_sys_rst(rst),
        .i_a_bus(a_wire), .i_b_bus(b_wire), .i_a_capture_clk(a_cap),
        .i_b_capture_clk(b_cap), .i_a_source_sel(a_sel), .i_b_source_sel(b_sel),
        .i_b_port_drive_en(b_en), .i_a_port_drive_en_n(a_en_n), .o_a_bus(a_out),
        .o_a_bus_oe_n(a_oe_n), .o_b_bus(b_out), .o_b_bus_oe_n(b_oe_n));
    rbt_bus_partner rbt_bus_partner_inst (.i_clk(clk), .i_a_drv(a_drv),
        .i_a_drv_en(a_drv_en), .i_b_drv(b_drv), .i_b_drv_en(b_drv_en), .i_a_dev(a_out),
        .i_a_dev_oe_n(a_oe_n), .i_b_dev(b_out), .i_b_dev_oe_n(b_oe_n),
        .o_a_wire(a_wire), .o_b_wire(b_wire));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic ctl(input logic ben, input logic aenn, input logic bs, input logic as);
        b_en = ben;
        a_en_n = aenn;
        b_sel = bs;
        a_sel = as;
        step(8);
    endtask
    // Capture clocks stay high and low for 3 cycles each
    task automatic cap(input logic a, input logic b);
        a_cap = a;
        b_cap = b;
        step(3);
        a_cap = 1'b0;
        b_cap = 1'b0;
        step(3);
    endtask
    task automatic t_live;
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        check8("a_oe_n", {7'h00, 1'b1}, {7'h00, a_oe_n});
        check8("b_oe_n", {7'h00, 1'b1}, {7'h00, b_oe_n});
        a_drv = 8'h5a;
        b_drv_en = 1'b0;
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        check8("b_wire", 8'h5a, b_wire);
        check8("a_oe_n", {7'h00, 1'b1}, {7'h00, a_oe_n});
        check8("b_oe_n", 8'h00, {7'h00, b_oe_n});
        b_drv = 8'ha5;
        b_drv_en = 1'b1;
        a_drv_en = 1'b0;
        ctl(1'b0, 1'b0, 1'b0, 1'b0);
        check8("a_wire", 8'ha5, a_wire);
        check8("a_oe_n", 8'h00, {7'h00, a_oe_n});
        check8("b_oe_n", {7'h00, 1'b1}, {7'h00, b_oe_n});
    endtask
    task automatic t_store;
        a_drv_en = 1'b1;
        a_drv = 8'hc3;
        b_drv = 8'h3c;
        ctl(1'b0, 1'b1, 1'b1, 1'b1);
        cap(1'b1, 1'b0);
        cap(1'b0, 1'b1);
        a_drv = 8'h11;
        b_drv = 8'h22;
        step(4);
        a_drv_en = 1'b0;
        b_drv_en = 1'b0;
        ctl(1'b1, 1'b0, 1'b1, 1'b1);
        check8("a_wire", 8'h3c, a_wire);
        check8("b_wire", 8'hc3, b_wire);
    endtask
    // Coincident edges with only one port driven live; both registers then hold one value
    task automatic t_both(input logic from_a, input logic [7:0] v);
        a_drv = v;
        b_drv = v;
        a_drv_en = from_a;
        b_drv_en = !from_a;
        ctl(from_a, from_a, 1'b0, 1'b0);
        cap(1'b1, 1'b1);
        a_drv_en = 1'b0;
        b_drv_en = 1'b0;
        ctl(1'b1, 1'b0, 1'b1, 1'b1);
        check8("a_wire", v, a_wire);
        check8("b_wire", v, b_wire);
    endtask
    task automatic t_loop;
        a_drv = 8'h96;
        a_drv_en = 1'b1;
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        a_drv_en = 1'b0;
        step(8);
        check8("a_wire", 8'h96, a_wire);
        check8("b_wire", 8'h96, b_wire);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        step(10);
        rst = 1'b0;
        step(2);
        t_live;
        t_store;
        t_both(1'b1, 8'h77);
        t_both(1'b0, 8'h99);
        t_loop;
        final_report;
    end
endmodule // testbench

/* File: verilog/rbt_bit_channel.sv */
// One bit channel: the two storage bits and the two registered port outputs.
// Assumes all inputs are already synchronous to i_clk.
`timescale 1ns/10ps
`include "rbt_regs.svh"
module rbt_bit_channel (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_a_live,
    input  wire logic       i_b_live,
    input  wire logic       i_a_cap,
    input  wire logic       i_b_cap,
    input  wire logic       i_a_edge,
    input  wire logic       i_b_edge,
    input  rbt_pkg::rbt_src_t i_a_sel,
    input  rbt_pkg::rbt_src_t i_b_sel,
    output logic            o_a_out,
    output logic            o_b_out,
    output logic            o_a_store,
    output logic            o_b_store
);
    typedef struct packed {
        logic a_store;
        logic b_store;
        logic a_out;
        logic b_out;
    } rbt_chan_state_t;

    rbt_chan_state_t st_d;
    rbt_chan_state_t st_q;

    always_comb
    begin
        st_d = st_q;
        // Capture ignores enables and selects; storage is never reset
        if (i_a_edge)
        begin
            st_d.a_store = i_a_cap;
        end
        if (i_b_edge)
        begin
            st_d.b_store = i_b_cap;
        end
        // Registered mux: the port only changes on a clock edge
        st_d.a_out = (i_a_sel == rbt_pkg::RBT_SRC_STORED) ? st_q.b_store
                                                          : i_b_live;
        st_d.b_out = (i_b_sel == rbt_pkg::RBT_SRC_STORED) ? st_q.a_store
                                                          : i_a_live;
        if (i_sys_rst)
        begin
            st_d.a_out = `RBT_OUT_RST;
            st_d.b_out = `RBT_OUT_RST;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st_q <= st_d;
    end

    assign o_a_out   = st_q.a_out;
    assign o_b_out   = st_q.b_out;
    assign o_a_store = st_q.a_store;
    assign o_b_store = st_q.b_store;
endmodule // rbt_bit_channel

/* File: verilog/rbt_pkg.sv */
// Types of the registered bidirectional bus transceiver.
// Assumes nothing of its surroundings.
package rbt_pkg;
    typedef enum logic {
        RBT_SRC_LIVE   = 1'b0,
        RBT_SRC_STORED = 1'b1
    } rbt_src_t;
endpackage

/* File: verilog/rbt_regs.svh */
// Constants of the registered bidirectional bus transceiver.
// Assumes inclusion by bare name from the design files of this block.
// Function
// - Each register captures its own bus on a rising edge of its own capture clock.
// - A low source select passes live data from the opposite bus, a high one the stored value.
// - Changing a source select never glitches the driven port output.
// - B drive enable high drives B, A drive enable low drives A, otherwise both are isolated.
// - With B driven and its select low, the live A value is driven onto B.
// - With A driven and its select low, the live B value is driven onto A.
// - With A driven and its select high, the B-side register is driven onto A.
// - With both driven and both selects high, each port shows the opposite register.
// - With both driven and both selects live, each port drives the live value of the opposite bus.
// - With only B driven from live A, coincident edges load the same A value into both registers.
// - With only A driven from live B, coincident edges load the same B value into both registers.
// - With only one port driven and its select low, coincident capture edges load both registers correctly.
// - The block is eight identical bit channels sharing all controls.
`ifndef RBT_REGS_SVH
`define RBT_REGS_SVH
`define RBT_WIDTH     8
`define RBT_CTL_W     6
`define RBT_CTL_A_CLK 0
`define RBT_CTL_B_CLK 1
`define RBT_CTL_A_SEL 2
`define RBT_CTL_B_SEL 3
`define RBT_CTL_B_EN  4
`define RBT_CTL_A_EN_N 5
`define RBT_CTL_RST   6'h20
`define RBT_PREV_RST  2'h3
`define RBT_OE_N_RST  2'h3
`define RBT_OUT_RST   1'b0
`endif

/* File: verilog/rbt_transceiver.sv */
// Registered bidirectional transceiver between an A bus and a B bus.
// Assumes all pin inputs are asynchronous; each bus pin is split into
// input, output and an output enable that is low while driving.
`timescale 1ns/10ps
`include "rbt_regs.svh"
module rbt_transceiver #(
    parameter int WIDTH = `RBT_WIDTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_a_bus,
    input  wire logic [WIDTH-1:0] i_b_bus,
    input  wire logic             i_a_capture_clk,
    input  wire logic             i_b_capture_clk,
    input  wire logic             i_a_source_sel,
    input  wire logic             i_b_source_sel,
    input  wire logic             i_b_port_drive_en,
    input  wire logic             i_a_port_drive_en_n,
    output logic      [WIDTH-1:0] o_a_bus,
    output logic                  o_a_bus_oe_n,
    output logic      [WIDTH-1:0] o_b_bus,
    output logic                  o_b_bus_oe_n
);
    typedef struct packed {
        logic [WIDTH-1:0]      a_s1;
        logic [WIDTH-1:0]      a_s2;
        logic [WIDTH-1:0]      b_s1;
        logic [WIDTH-1:0]      b_s2;
        logic [`RBT_CTL_W-1:0] ctl_s1;
        logic [`RBT_CTL_W-1:0] ctl_s2;
        logic [1:0]            clk_prev;
        logic [1:0]            oe_n;
    } rbt_top_state_t;

    rbt_top_state_t   st_d;
    rbt_top_state_t   st_q;
    logic             a_edge;
    logic             b_edge;
    logic             a_drive;
    logic             b_drive;
    logic             a_sel;
    logic             b_sel;
    logic [WIDTH-1:0] a_cap;
    logic [WIDTH-1:0] b_cap;
    logic [WIDTH-1:0] a_store;
    logic [WIDTH-1:0] b_store;

    always_comb
    begin
        st_d          = st_q;
        st_d.a_s1     = i_a_bus;
        st_d.a_s2     = st_q.a_s1;
        st_d.b_s1     = i_b_bus;
        st_d.b_s2     = st_q.b_s1;
        st_d.ctl_s1   = {i_a_port_drive_en_n, i_b_port_drive_en, i_b_source_sel,
                         i_a_source_sel, i_b_capture_clk, i_a_capture_clk};
        st_d.ctl_s2   = st_q.ctl_s1;
        st_d.clk_prev = {st_q.ctl_s2[`RBT_CTL_B_CLK], st_q.ctl_s2[`RBT_CTL_A_CLK]};
        st_d.oe_n[0]  = st_q.ctl_s2[`RBT_CTL_A_EN_N];
        st_d.oe_n[1]  = ~st_q.ctl_s2[`RBT_CTL_B_EN];
        if (i_sys_rst)
        begin
            st_d.ctl_s1   = `RBT_CTL_RST;
            st_d.ctl_s2   = `RBT_CTL_RST;
            st_d.clk_prev = `RBT_PREV_RST;
            st_d.oe_n     = `RBT_OE_N_RST;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st_q <= st_d;
    end

    assign a_edge  = st_q.ctl_s2[`RBT_CTL_A_CLK] & ~st_q.clk_prev[0];
    assign b_edge  = st_q.ctl_s2[`RBT_CTL_B_CLK] & ~st_q.clk_prev[1];
    assign a_sel   = st_q.ctl_s2[`RBT_CTL_A_SEL];
    assign b_sel   = st_q.ctl_s2[`RBT_CTL_B_SEL];
    assign b_drive = st_q.ctl_s2[`RBT_CTL_B_EN];
    assign a_drive = ~st_q.ctl_s2[`RBT_CTL_A_EN_N];

    // A one-way live drive feeds the far register straight from the source,
    // so coincident edges see one value instead of the lagging pin echo
    assign a_cap = (a_drive && !b_drive && !a_sel) ? st_q.b_s2 : st_q.a_s2;
    assign b_cap = (b_drive && !a_drive && !b_sel) ? st_q.a_s2 : st_q.b_s2;

    for (genvar g = 0; g < WIDTH; g++)
    begin : g_chan
        rbt_bit_channel u_chan (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_a_live  (st_q.a_s2[g]),
            .i_b_live  (st_q.b_s2[g]),
            .i_a_cap   (a_cap[g]),
            .i_b_cap   (b_cap[g]),
            .i_a_edge  (a_edge),
            .i_b_edge  (b_edge),
            .i_a_sel   (rbt_pkg::rbt_src_t'(a_sel)),
            .i_b_sel   (rbt_pkg::rbt_src_t'(b_sel)),
            .o_a_out   (o_a_bus[g]),
            .o_b_out   (o_b_bus[g]),
            .o_a_store (a_store[g]),
            .o_b_store (b_store[g])
        );
    end

    assign o_a_bus_oe_n = st_q.oe_n[0];
    assign o_b_bus_oe_n = st_q.oe_n[1];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_a_capture_load: assert property (a_edge |=> a_store == $past(a_cap))
        else $error("A register missed its capture");
    // Storage is unknown until its first capture, so compare case-equal
    a_b_capture_hold: assert property (!b_edge |=> b_store === $past(b_store))
        else $error("B register changed without a capture edge");
    a_b_live_path: assert property (!b_sel ##1 !b_sel |=> o_b_bus == $past(st_q.a_s1, 2))
        else $error("B port not showing live A data");
    a_a_live_path: assert property (!a_sel |=> o_a_bus == $past(st_q.b_s2))
        else $error("A port not showing live B data");
    a_a_stored_path: assert property (a_sel |=> o_a_bus === $past(b_store))
        else $error("A port not showing B register");
    a_both_stored: assert property ((a_sel && b_sel) |=>
        (o_a_bus === $past(b_store)) && (o_b_bus === $past(a_store)))
        else $error("Stored cross drive wrong");
    a_port_drive: assert property (1'b1 |=> (o_b_bus_oe_n == !$past(b_drive))
        && (o_a_bus_oe_n == !$past(a_drive)))
        else $error("Port enable does not follow its drive control");
    a_isolation: assert property ((!b_drive && !a_drive) [*2] |-> o_a_bus_oe_n && o_b_bus_oe_n)
        else $error("Port driven while isolated");
    a_b_oneway_pair: assert property ((a_edge && b_edge && b_drive && !a_drive && !b_sel)
        |=> a_store == b_store)
        else $error("Coincident edges loaded different values from A");
    a_a_oneway_pair: assert property ((a_edge && b_edge && a_drive && !b_drive && !a_sel)
        |=> a_store == b_store)
        else $error("Coincident edges loaded different values from B");
endmodule // rbt_transceiver
